// ### core/ddt_defs.vh
// constants shared by the dual down-counter timer files
`ifndef DDT_DEFS_VH
`define DDT_DEFS_VH

// register word index inside one unit window
`define DDT_OFS_LOAD 3'h0
`define DDT_OFS_VALUE 3'h1
`define DDT_OFS_CONTROL 3'h2
`define DDT_OFS_INTCLR 3'h3
`define DDT_OFS_RAWSTAT 3'h4
`define DDT_OFS_MASKSTAT 3'h5
`define DDT_OFS_BGLOAD 3'h6
// unit windows start at 0x000 and 0x020; the identity word sits at 0xFE0
`define DDT_ADDR_ID 10'h3F8

// control register fields
`define DDT_CTL_ONESHOT 0
`define DDT_CTL_SIZE32 1
`define DDT_CTL_PRE_LO 2
`define DDT_CTL_PRE_HI 3
`define DDT_CTL_INTEN 5
`define DDT_CTL_PERIODIC 6
`define DDT_CTL_ENABLE 7
`define DDT_CTL_WIDTH 8

// prescale codes
`define DDT_PRE_DIV1 2'h0
`define DDT_PRE_DIV16 2'h1
`define DDT_PRE_DIV256 2'h2

// prescaler terminal counts that issue a count pulse
`define DDT_PRE16_LAST 4'hF
`define DDT_PRE256_LAST 8'hFF

// reset values
`define DDT_RST_CONTROL 8'h20
`define DDT_RST_LOAD 32'h00000000
`define DDT_RST_VALUE 32'hFFFFFFFF

// ahb encodings
`define DDT_HTRANS_NONSEQ 2'h2
`define DDT_HTRANS_SEQ 2'h3
`define DDT_HSIZE_WORD 3'h2

`endif

// ### core/ddt_unit.v
// one down-counter unit: prescaler, counter, load paths and raw interrupt
`timescale 1ns/1ns
`include "ddt_defs.vh"

module ddt_unit (
  input wire clk,
  input wire reset,
  input wire count_clock_enable,
  input wire run,
  input wire one_shot,
  input wire periodic,
  input wire size32,
  input wire [1:0] prescale,
  input wire load_write,
  input wire bg_load_write,
  input wire [31:0] write_data,
  input wire int_clear,
  output reg [31:0] load_value,
  output reg [31:0] count_value,
  output reg raw_int,
  output wire next_raw_int
);

  reg [7:0] pre_count;
  reg load_pending;
  reg halted;
  wire tick;
  wire at_zero;
  wire step;
  wire zero_event;

  // ==========================================================
  // prescaler
  assign tick = (prescale == `DDT_PRE_DIV1) ||
                ((prescale == `DDT_PRE_DIV16) && (pre_count[3:0] == `DDT_PRE16_LAST)) ||
                ((prescale != `DDT_PRE_DIV1) && (prescale != `DDT_PRE_DIV16) &&
                 (pre_count == `DDT_PRE256_LAST));

  // ==========================================================
  // counter
  assign at_zero = size32 ? (count_value == 32'h00000000) :
                   (count_value[15:0] == 16'h0000);
  assign step = count_clock_enable && !load_pending && tick && run && !halted;
  assign zero_event = step && at_zero;
  // set wins over a clear in the same cycle
  assign next_raw_int = zero_event | (raw_int & ~int_clear);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      pre_count <= 8'h00;
      load_pending <= 1'b0;
      halted <= 1'b0;
      load_value <= `DDT_RST_LOAD;
      count_value <= `DDT_RST_VALUE;
      raw_int <= 1'b0;
    end else begin
      raw_int <= next_raw_int;
      if (count_clock_enable) begin
        pre_count <= pre_count + 8'h01;
        if (load_pending) begin
          count_value <= load_value;
          load_pending <= 1'b0;
          pre_count <= 8'h00;
        end else if (step) begin
          if (at_zero) begin
            if (one_shot) begin
              halted <= 1'b1;
            end else if (periodic) begin
              if (size32) begin
                count_value <= load_value;
              end else begin
                count_value <= {count_value[31:16], load_value[15:0]};
              end
            end else begin
              if (size32) begin
                count_value <= 32'hFFFFFFFF;
              end else begin
                count_value <= {count_value[31:16], 16'hFFFF};
              end
            end
          end else if (size32) begin
            count_value <= count_value - 32'h00000001;
          end else begin
            count_value <= {count_value[31:16], count_value[15:0] - 16'h0001};
          end
        end
      end
      // background load changes only the reload value
      if (bg_load_write) begin
        load_value <= write_data;
      end
      // a load write restarts the count, overriding a pending one
      if (load_write) begin
        load_value <= write_data;
        load_pending <= 1'b1;
        halted <= 1'b0;
      end
    end
  end

endmodule // ddt_unit

// ### core/ddt_top.v
// dual down-counter timer: ahb-lite slave, register file and two counter units
`timescale 1ns/1ns
`include "ddt_defs.vh"

module ddt_top #(
  // identity word, value is arbitrary
  parameter [31:0] IDENT_WORD = 32'h0000D7D7
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire UNIT1_COUNT_CLOCK_ENABLE,
  input wire UNIT2_COUNT_CLOCK_ENABLE,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  output reg UNIT1_INTERRUPT_OUTPUT,
  output reg UNIT2_INTERRUPT_OUTPUT
);

  // ==========================================================
  // address phase capture

  reg wr_phase;
  reg [9:0] wr_word;
  wire addr_valid;
  wire take_write;
  wire take_read;
  wire [9:0] addr_word;

  assign addr_word = HADDR[11:2];
  assign addr_valid = HSEL && HREADY &&
                      ((HTRANS == `DDT_HTRANS_NONSEQ) || (HTRANS == `DDT_HTRANS_SEQ));
  // only whole-word writes are taken
  assign take_write = addr_valid && HWRITE && (HSIZE == `DDT_HSIZE_WORD);
  assign take_read = addr_valid && !HWRITE;

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      wr_phase <= 1'b0;
      wr_word <= 10'h000;
    end else begin
      if (HREADY) begin
        wr_phase <= take_write;
        if (take_write) begin
          wr_word <= addr_word;
        end
      end
    end
  end

  // ==========================================================
  // data phase write decode

  wire wr_unit_window;
  wire wr_unit;
  wire [2:0] wr_ofs;

  assign wr_unit_window = wr_phase && (wr_word[9:4] == 6'h00) && !wr_word[2]
                          ? 1'b1 : (wr_phase && (wr_word[9:4] == 6'h00) &&
                          (wr_word[2:0] != 3'h7));
  assign wr_unit = wr_word[3];
  assign wr_ofs = wr_word[2:0];

  // ==========================================================
  // per-unit registers and counters

  wire [1:0] unit_clock_enable;
  wire [63:0] unit_load;
  wire [63:0] unit_value;
  wire [15:0] unit_control;
  wire [1:0] unit_raw;
  wire [1:0] unit_next_raw;
  wire [1:0] unit_int_clear;

  assign unit_clock_enable = {UNIT2_COUNT_CLOCK_ENABLE, UNIT1_COUNT_CLOCK_ENABLE};

  genvar u;
  generate
    for (u = 0; u < 2; u = u + 1) begin : g_unit
      reg [`DDT_CTL_WIDTH-1:0] control;
      wire sel;
      wire load_write;
      wire bg_load_write;
      wire control_write;

      assign sel = wr_unit_window && (wr_unit == u);
      assign load_write = sel && (wr_ofs == `DDT_OFS_LOAD);
      assign bg_load_write = sel && (wr_ofs == `DDT_OFS_BGLOAD);
      assign control_write = sel && (wr_ofs == `DDT_OFS_CONTROL);
      assign unit_int_clear[u] = sel && (wr_ofs == `DDT_OFS_INTCLR);
      assign unit_control[u*8 +: 8] = control;

      always @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          control <= `DDT_RST_CONTROL;
        end else if (control_write) begin
          control <= HWDATA[`DDT_CTL_WIDTH-1:0];
        end
      end

      ddt_unit u_unit (
        .clk(CLK_SYS),
        .reset(RESET),
        .count_clock_enable(unit_clock_enable[u]),
        .run(control[`DDT_CTL_ENABLE]),
        .one_shot(control[`DDT_CTL_ONESHOT]),
        .periodic(control[`DDT_CTL_PERIODIC]),
        .size32(control[`DDT_CTL_SIZE32]),
        .prescale(control[`DDT_CTL_PRE_HI:`DDT_CTL_PRE_LO]),
        .load_write(load_write),
        .bg_load_write(bg_load_write),
        .write_data(HWDATA),
        .int_clear(unit_int_clear[u]),
        .load_value(unit_load[u*32 +: 32]),
        .count_value(unit_value[u*32 +: 32]),
        .raw_int(unit_raw[u]),
        .next_raw_int(unit_next_raw[u])
      );
    end
  endgenerate

  // ==========================================================
  // read data selection

  reg [31:0] next_rdata;
  reg [7:0] rd_control;
  reg [31:0] rd_load;
  reg [31:0] rd_value;
  reg rd_raw;

  always @* begin
    next_rdata = 32'h00000000;
    if (addr_word[3]) begin
      rd_control = unit_control[15:8];
      rd_load = unit_load[63:32];
      rd_value = unit_value[63:32];
      rd_raw = unit_raw[1];
    end else begin
      rd_control = unit_control[7:0];
      rd_load = unit_load[31:0];
      rd_value = unit_value[31:0];
      rd_raw = unit_raw[0];
    end
    if (addr_word == `DDT_ADDR_ID) begin
      next_rdata = IDENT_WORD;
    end else if (addr_word[9:4] == 6'h00) begin
      case (addr_word[2:0])
        `DDT_OFS_LOAD: begin
          next_rdata = rd_load;
        end
        `DDT_OFS_VALUE: begin
          next_rdata = rd_value;
        end
        `DDT_OFS_CONTROL: begin
          next_rdata = {24'h000000, rd_control};
        end
        `DDT_OFS_RAWSTAT: begin
          next_rdata = {31'h00000000, rd_raw};
        end
        `DDT_OFS_MASKSTAT: begin
          next_rdata = {31'h00000000, rd_raw & rd_control[`DDT_CTL_INTEN]};
        end
        `DDT_OFS_BGLOAD: begin
          next_rdata = rd_load;
        end
        default: begin
          next_rdata = 32'h00000000;
        end
      endcase
    end
  end

  // ==========================================================
  // bus outputs, zero wait states, always OKAY

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (take_read) begin
        HRDATA <= next_rdata;
      end
    end
  end

  // ==========================================================
  // interrupt pins
  // pins follow the raw state of the same edge, so a clear write drops them at once

  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      UNIT1_INTERRUPT_OUTPUT <= 1'b0;
      UNIT2_INTERRUPT_OUTPUT <= 1'b0;
    end else begin
      UNIT1_INTERRUPT_OUTPUT <= unit_next_raw[0] & unit_control[`DDT_CTL_INTEN];
      UNIT2_INTERRUPT_OUTPUT <= unit_next_raw[1] & unit_control[8 + `DDT_CTL_INTEN];
    end
  end

endmodule // ddt_top

// ### verification/ddt_top_asserts.sv
// checker for the timer's bus and interrupt pins
`timescale 1ns/1ns
module ddt_chk #(
  parameter [31:0] IDENT_WORD = 32'h00000000
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  input wire UNIT1_INTERRUPT_OUTPUT,
  input wire UNIT2_INTERRUPT_OUTPUT,
  input wire UNIT1_COUNT_CLOCK_ENABLE,
  input wire UNIT2_COUNT_CLOCK_ENABLE
);
  // ==========
  // data phase tracking
  wire rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
  reg ph_wr;
  reg [11:0] ph_adr;
  wire clr1 = ph_wr && ph_adr == 12'h00C;
  wire clr2 = ph_wr && ph_adr == 12'h02C;
  wire ctl1 = ph_wr && ph_adr == 12'h008;
  always @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ph_wr <= 1'b0;
      ph_adr <= 12'h000;
    end else if (HREADY) begin
      ph_wr <= HSEL && HTRANS[1] && HWRITE && HSIZE == 3'h2;
      ph_adr <= HADDR[11:0];
    end
  end
  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);
  sequence id_rd_s;
    rd && HADDR[11:0] == 12'hFE0;
  endsequence
  sequence hole_rd_s;
    rd && HADDR[11:6] != 6'h00 && HADDR[11:2] != 10'h3F8;
  endsequence
  // ==========
  // assertions
  ready_high_a: assert property (HREADYOUT)
    else $error("ready low");
  resp_okay_a: assert property (HRESP == 1'b0)
    else $error("error response");
  id_read_a: assert property (id_rd_s |=> HRDATA == IDENT_WORD)
    else $error("identity word wrong");
  hole_zero_a: assert property (hole_rd_s |=> HRDATA == 32'h0)
    else $error("unmapped read not zero");
  status_bits_a: assert property (rd && HADDR[11:6] == 6'h00 && HADDR[4:3] == 2'h2
    |=> HRDATA[31:1] == 31'h0) else $error("status upper bits set");
  rdata_hold_a: assert property (!rd |=> $stable(HRDATA))
    else $error("read data moved without a read");
  // a zero reached on the clear edge sets the flag again, so only clears without a count edge
  clear_one_a: assert property (clr1 && !UNIT1_COUNT_CLOCK_ENABLE |=> !UNIT1_INTERRUPT_OUTPUT)
    else $error("unit 1 pin not cleared");
  clear_two_a: assert property (clr2 && !UNIT2_COUNT_CLOCK_ENABLE |=> !UNIT2_INTERRUPT_OUTPUT)
    else $error("unit 2 pin not cleared");
  pin_fall_a: assert property ($fell(UNIT1_INTERRUPT_OUTPUT)
    |-> $past(clr1) || $past(ctl1, 2)) else $error("unit 1 pin fell without cause");
endmodule // ddt_chk

// ### verification/ddt_master.sv
// bus master model issuing single word transfers
`timescale 1ns/1ns
module ddt_master (
  input wire clk,
  input wire ready,
  input wire [31:0] rdata,
  output reg sel,
  output reg [31:0] addr,
  output reg [1:0] trans,
  output reg write,
  output reg [2:0] size,
  output reg [31:0] wdata
);
  initial begin
    sel = 1'b0;
    addr = 32'h0;
    trans = 2'h0;
    write = 1'b0;
    size = 3'h2;
    wdata = 32'h0;
  end
  // ==========
  // one transfer, entered just after a rising edge
  task xfer(input w, input [31:0] a, input [31:0] d, output [31:0] q);
    begin
      sel <= 1'b1;
      addr <= a;
      trans <= 2'h2;
      write <= w;
      @(posedge clk);
      while (!ready) @(posedge clk);
      sel <= 1'b0;
      trans <= 2'h0;
      addr <= ~a;
      wdata <= w ? d : ~wdata;
      @(posedge clk);
      while (!ready) @(posedge clk);
      q = rdata;
    end
  endtask
endmodule // ddt_master

// ### verification/ddt_tb.sv
// self-checking bench for the dual down-counter timer
`timescale 1ns/1ns
module testbench;
  // identity word, value is arbitrary
  localparam [31:0] ID_WORD = 32'h00005A5A;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [1:0] en = 2'h0;
  wire hsel, hwrite, hrdy, hresp, int1, int2;
  wire [31:0] haddr, hwdata, hrdata;
  wire [1:0] htrans;
  wire [2:0] hsize;
  integer fails = 0;
  integer comparisons = 0;
  reg [31:0] q;
  always #10 clk = ~clk;
  ddt_top #(.IDENT_WORD(ID_WORD)) i_dut (.CLK_SYS(clk), .RESET(rst),
    .UNIT1_COUNT_CLOCK_ENABLE(en[0]), .UNIT2_COUNT_CLOCK_ENABLE(en[1]),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
    .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy),
    .HRESP(hresp), .UNIT1_INTERRUPT_OUTPUT(int1), .UNIT2_INTERRUPT_OUTPUT(int2));
  ddt_master i_mst (.clk(clk), .ready(hrdy), .rdata(hrdata), .sel(hsel),
    .addr(haddr), .trans(htrans), .write(hwrite), .size(hsize), .wdata(hwdata));
  // ==========
  // shared tasks
  task chk(input [31:0] nm, input [31:0] s, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (s !== e) begin
        fails = fails + 1;
        $display("wrong value %0s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    i_mst.xfer(1'b1, {20'h00000, a}, d, q);
  endtask
  task rc(input [31:0] nm, input [11:0] a, input [31:0] e);
    begin
      i_mst.xfer(1'b0, {20'h00000, a}, 32'h0, q);
      chk(nm, q, e);
    end
  endtask
  task pulse(input integer u, input integer n);
    begin
      repeat (n) begin
        en[u] <= 1'b1;
        @(posedge clk);
      end
      en[u] <= 1'b0;
      @(posedge clk);
    end
  endtask
  // ==========
  // scenarios
  task t_reset;
    begin
      rc("ctl", 12'h008, 32'h20);
      rc("ctl", 12'h028, 32'h20);
      rc("load", 12'h000, 32'h0);
      rc("raw", 12'h010, 32'h0);
      rc("id", 12'hFE0, ID_WORD);
      rc("none", 12'h100, 32'h0);
      wr(12'h100, 32'h5);
      wr(12'h024, 32'h5);
      rc("val", 12'h024, 32'hFFFFFFFF);
    end
  endtask
  task t_free;
    begin
      wr(12'h028, 32'hA0);
      wr(12'h020, 32'h00010002);
      pulse(1, 1);
      rc("val", 12'h024, 32'h00010002);
      pulse(1, 2);
      rc("val", 12'h024, 32'h00010000);
      rc("raw", 12'h030, 32'h0);
      pulse(1, 1);
      rc("val", 12'h024, 32'h0001FFFF);
      rc("raw", 12'h030, 32'h1);
      chk("pin", {31'h0, int2}, 32'h1);
      rc("val", 12'h004, 32'hFFFFFFFF);
      wr(12'h02C, 32'h12345678);
      rc("raw", 12'h030, 32'h0);
      chk("pin", {31'h0, int2}, 32'h0);
    end
  endtask
  task t_pre;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        wr(12'h008, 32'hA0 + 4 * k);
        wr(12'h000, 32'h5);
        pulse(0, 1);
        pulse(0, (k == 0) ? 0 : (k == 1) ? 15 : 255);
        rc("pre", 12'h004, 32'h5);
        pulse(0, 1);
        rc("pre", 12'h004, 32'h4);
      end
    end
  endtask
  task t_per;
    begin
      wr(12'h008, 32'hE2);
      wr(12'h000, 32'h2);
      pulse(0, 1);
      wr(12'h018, 32'h7);
      rc("val", 12'h004, 32'h2);
      rc("load", 12'h000, 32'h7);
      pulse(0, 3);
      rc("val", 12'h004, 32'h7);
      wr(12'h00C, 32'h0);
      rc("raw", 12'h010, 32'h0);
      pulse(0, 2);
      wr(12'h000, 32'h3);
      pulse(0, 1);
      rc("val", 12'h004, 32'h3);
    end
  endtask
  task t_one;
    begin
      wr(12'h008, 32'hA1);
      wr(12'h000, 32'h1);
      pulse(0, 8);
      rc("val", 12'h004, 32'h0);
      wr(12'h008, 32'h81);
      rc("mis", 12'h014, 32'h0);
      rc("raw", 12'h010, 32'h1);
      chk("pin", {31'h0, int1}, 32'h0);
      wr(12'h008, 32'hA1);
      rc("mis", 12'h014, 32'h1);
      chk("pin", {31'h0, int1}, 32'h1);
      wr(12'h00C, 32'h0);
      rc("mis", 12'h014, 32'h0);
    end
  endtask
  task t_misc;
    begin
      wr(12'h028, 32'h22);
      wr(12'h020, 32'h3);
      pulse(1, 3);
      rc("val", 12'h024, 32'h3);
      wr(12'h028, 32'hA2);
      pulse(1, 4);
      rc("val", 12'h024, 32'hFFFFFFFF);
      rc("raw", 12'h030, 32'h1);
      wr(12'h02C, 32'h0);
      wr(12'h028, 32'hE0);
      wr(12'h020, 32'h00050001);
      pulse(1, 1);
      wr(12'h038, 32'h00090002);
      pulse(1, 2);
      rc("val", 12'h024, 32'h00050002);
      chk("pin", {31'h0, int2}, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rc("ctl", 12'h028, 32'h20);
      rc("val", 12'h024, 32'hFFFFFFFF);
      chk("pin", {31'h0, int2}, 32'h0);
    end
  endtask
  task print_verdict;
    begin
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
        $display("RESULT: PASS");
      end else begin
        $display("RESULT: FAIL");
      end
      $finish;
    end
  endtask
  initial begin
    #200000;
    fails = fails + 1;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_free;
    t_pre;
    t_per;
    t_one;
    t_misc;
    print_verdict;
  end
endmodule // testbench
bind ddt_top ddt_chk #(.IDENT_WORD(IDENT_WORD)) i_chk (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .UNIT1_INTERRUPT_OUTPUT(UNIT1_INTERRUPT_OUTPUT),
  .UNIT2_INTERRUPT_OUTPUT(UNIT2_INTERRUPT_OUTPUT),
  .UNIT1_COUNT_CLOCK_ENABLE(UNIT1_COUNT_CLOCK_ENABLE),
  .UNIT2_COUNT_CLOCK_ENABLE(UNIT2_COUNT_CLOCK_ENABLE));
